// *** shared/tcpo_pkg.sv ***
// Shared constants and carrier types for the Type-C port ownership block
package tcpo_pkg;
  localparam int unsigned NUM_LANES      = 4;     // Main-link lanes per port
  localparam int unsigned LANE_CFG_W     = 4;     // Lane assignment field width
  localparam int unsigned LIVE_W         = 2;     // Live-state field width
  localparam int unsigned MODE_STAT_W    = 4;     // Lane-mode status word width
  localparam int unsigned CTRL_W         = 4;     // Safe-state control word width
  localparam int unsigned NUM_REQ        = 2;     // Boot and driver request sets
  localparam int unsigned CLK_MHZ        = 250;   // Core clock rate
  localparam int unsigned PWR_SETTLE_NS  = 2000;  // Aux IO power settle time
  localparam int unsigned PWR_SETTLE_CYC = (PWR_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_W       = 10;    // Settle counter width
  localparam int unsigned MBOX_CMD_W     = 8;     // Mailbox command width
  localparam logic [MBOX_CMD_W-1:0] MBOX_EXIT_COLD = 8'h12; // Cold-state exit code
  localparam int unsigned MBOX_BUSY_NS   = 1000;  // Mailbox processing time
  localparam int unsigned MBOX_BUSY_CYC  = (MBOX_BUSY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned COLD_HOLD_MS   = 500;   // Guaranteed stay out of cold state
  localparam int unsigned COLD_HOLD_CYC  = COLD_HOLD_MS * CLK_MHZ * 1000;
  localparam int unsigned HOLD_W         = 28;    // Cold-hold counter width
  localparam logic [LIVE_W-1:0] LIVE_NONE   = 2'h0; // No connection
  localparam logic [LIVE_W-1:0] LIVE_ALT    = 2'h1; // Alternate-mode connection
  localparam logic [LIVE_W-1:0] LIVE_TUNNEL = 2'h2; // Tunneled connection
  localparam logic AUX_SEL_LEGACY = 1'b0;        // Aux path select: legacy
  localparam logic AUX_SEL_TUNNEL = 1'b1;        // Aux path select: tunnel

  // Aux power request carrier for one requester set
  typedef struct packed {
    logic tunnel_req;   // Tunneled IO power request
    logic legacy_req;   // Non-tunneled IO power request
  } tcpo_aux_req_t;

  // Aux power state carrier
  typedef struct packed {
    logic tunnel_on;    // Tunneled IO power state
    logic legacy_on;    // Non-tunneled IO power state
  } tcpo_aux_state_t;
endpackage

// *** design/tcpo_aux_power.sv ***
// Aux IO power sequencer: takes the ORed request, settle delay, cold-state gating
`timescale 1ns/1ps
module tcpo_aux_power #(
  parameter int unsigned SETTLE_CYC = tcpo_pkg::PWR_SETTLE_CYC
) (
  input  wire logic CLK,
  input  wire logic SYS_RST,
  input  wire logic any_req,    // OR of all requesters for this path
  input  wire logic cold,       // Subsystem in cold state
  output logic      pwr_on      // Power state acknowledge
);
  import tcpo_pkg::*;

  // Whole state of the sequencer
  typedef struct packed {
    logic [SETTLE_W-1:0] cnt;   // Settle counter
    logic                on;    // Acknowledge flop
  } tcpo_pwr_state_t;

  tcpo_pwr_state_t st_q;        // Registered state
  tcpo_pwr_state_t st_d;        // Next state

  // Count up while requested; ack only once stable, never in cold state
  always_comb
  begin
    st_d = st_q;
    if (!any_req || cold)
    begin
      // Power drops only when no requester remains, or ack held off in cold
      st_d.cnt = '0;
      st_d.on  = 1'b0;
    end
    else if (st_q.cnt < SETTLE_W'(SETTLE_CYC))
    begin
      st_d.cnt = st_q.cnt + SETTLE_W'(1);
    end
    else
    begin
      st_d.on = 1'b1;
    end
  end

  // State register
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign pwr_on = st_q.on;
endmodule // tcpo_aux_power

// *** design/tcpo_port_own.sv ***
// Type-C port ownership handshake, aux power and lane control logic
// Overview of operation
// - Device reports lane assignment field to software
// - Separate tunneled and non-tunneled power requests
// - Per-lane main-link enables for unused lanes
// - Legacy connector reversal applied inside engine
// - Request sets power state after settling
// - Power stays on while other requesters hold
// - Two independent request sets, boot and driver
// - Cold state: mode, control, live and lane-config reads all ones, lane-mux writes ignored
// - Mailbox code 0x12 sets busy, clears when done
// - No ack in cold; request blocks entry
`timescale 1ns/1ps
module tcpo_port_own #(
  parameter int unsigned MBOX_CYC = tcpo_pkg::MBOX_BUSY_CYC,
  parameter int unsigned HOLD_CYC = tcpo_pkg::COLD_HOLD_CYC
) (
  input  wire logic                                  CLK,
  input  wire logic                                  SYS_RST,
  // Software side: safe-state control
  input  wire logic                                  SW_EXIT_WR,
  input  wire logic                                  SW_EXIT_VAL,
  // Software side: per-lane enables
  input  wire logic                                  SW_LANE_WR,
  input  wire logic [tcpo_pkg::NUM_LANES-1:0]        SW_LANE_EN,
  // Software side: aux path select and reversal
  input  wire logic                                  SW_AUX_SEL,
  input  wire logic                                  SW_REVERSE,
  // Software side: two request sets
  input  wire tcpo_pkg::tcpo_aux_req_t               SW_REQ_BOOT,
  input  wire tcpo_pkg::tcpo_aux_req_t               SW_REQ_DRV,
  // Software side: mailbox
  input  wire logic                                  MBOX_WR,
  input  wire logic [tcpo_pkg::MBOX_CMD_W-1:0]       MBOX_CMD,
  output logic                                       MBOX_BUSY,
  // Firmware side
  input  wire logic                                  FW_LANE_DP,
  input  wire logic [tcpo_pkg::LIVE_W-1:0]           FW_LIVE,
  input  wire logic [tcpo_pkg::LANE_CFG_W-1:0]       FW_LANE_CFG,
  input  wire logic                                  FW_PORT_IDLE,
  input  wire logic                                  FW_TYPEC_CONN,
  output logic                                       COLD_STATE,
  // Software-visible readback
  output logic [tcpo_pkg::MODE_STAT_W-1:0]           RD_MODE_STAT,
  output logic [tcpo_pkg::CTRL_W-1:0]                RD_CTRL,
  output logic [tcpo_pkg::LIVE_W-1:0]                RD_LIVE,
  output logic [tcpo_pkg::LANE_CFG_W-1:0]            RD_LANE_CFG,
  output tcpo_pkg::tcpo_aux_state_t                  RD_AUX_STATE,
  // To lane mux and PHY
  output logic                                       SAFE_MODE_EXIT,
  output logic [tcpo_pkg::NUM_LANES-1:0]             LANE_ENABLE,
  output logic [tcpo_pkg::NUM_LANES-1:0]             LANE_MAP_REVERSED,
  output logic                                       AUX_PATH_SEL
);
  import tcpo_pkg::*;

  // Whole state of the block
  typedef struct packed {
    logic                  exit_bit;   // Safe-mode-exit handshake bit
    logic [NUM_LANES-1:0]  lane_en;    // Main-link lane enables
    logic                  aux_sel;    // Aux path select
    logic                  reverse;    // Internal lane reversal
    logic                  cold;       // Subsystem cold state
    logic                  mbox_busy;  // Mailbox run-busy flag
    logic [HOLD_W-1:0]     mbox_cnt;   // Mailbox processing counter
    logic [HOLD_W-1:0]     hold_cnt;   // Cold re-entry hold-off counter
    logic [MODE_STAT_W-1:0] mode_rd;   // Mode status readback
    logic [CTRL_W-1:0]     ctrl_rd;    // Control readback
    logic [LIVE_W-1:0]     live_rd;    // Live-state readback
    logic [LANE_CFG_W-1:0] cfg_rd;     // Lane assignment readback
    logic [NUM_LANES-1:0]  map_rd;     // Lane map to PHY
  } tcpo_state_t;

  tcpo_state_t st_q;                   // Registered state
  tcpo_state_t st_d;                   // Next state

  logic            any_tun;            // Any tunneled requester
  logic            any_leg;            // Any non-tunneled requester
  tcpo_aux_state_t pwr;                // Power acknowledges
  logic            keep_awake;         // Something blocks cold entry

  // Requesters from both sets OR together per path
  assign any_tun = SW_REQ_BOOT.tunnel_req | SW_REQ_DRV.tunnel_req;
  assign any_leg = SW_REQ_BOOT.legacy_req | SW_REQ_DRV.legacy_req;

  // Tunneled aux IO power path
  tcpo_aux_power u_pwr_tun (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .any_req (any_tun),
    .cold    (st_q.cold),
    .pwr_on  (pwr.tunnel_on)
  );

  // Non-tunneled aux IO power path
  tcpo_aux_power u_pwr_leg (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .any_req (any_leg),
    .cold    (st_q.cold),
    .pwr_on  (pwr.legacy_on)
  );

  // Cold entry is blocked by requests, handshake bit, hold window or mailbox busy
  assign keep_awake = any_tun | any_leg | st_q.exit_bit
                    | (st_q.hold_cnt != '0) | st_q.mbox_busy;

  // Next-state logic
  always_comb
  begin
    st_d = st_q;
    // Cold state: entry only when idle and nothing holds, exit on connect
    if (st_q.cold)
    begin
      // Requests alone never wake the subsystem
      if (FW_TYPEC_CONN)
        st_d.cold = 1'b0;
    end
    else if (FW_PORT_IDLE && !keep_awake)
    begin
      st_d.cold = 1'b1;
    end
    // Mailbox: exit command sets busy, processing wakes subsystem
    if (st_q.mbox_busy)
    begin
      if (st_q.mbox_cnt == '0)
      begin
        st_d.mbox_busy = 1'b0;
        st_d.cold      = 1'b0;
        st_d.hold_cnt  = HOLD_W'(HOLD_CYC);
      end
      else
      begin
        st_d.mbox_cnt = st_q.mbox_cnt - HOLD_W'(1);
      end
    end
    else if (MBOX_WR && MBOX_CMD == MBOX_EXIT_COLD)
    begin
      // Other command codes are ignored; busy rejects new writes
      st_d.mbox_busy = 1'b1;
      st_d.mbox_cnt  = HOLD_W'(MBOX_CYC);
    end
    else if (st_q.hold_cnt != '0)
    begin
      st_d.hold_cnt = st_q.hold_cnt - HOLD_W'(1);
    end
    // Lane-mux registers freeze in cold state
    if (!st_q.cold)
    begin
      if (SW_EXIT_WR)
        st_d.exit_bit = SW_EXIT_VAL;
      if (SW_LANE_WR)
        st_d.lane_en = SW_LANE_EN;
    end
    else
    begin
      st_d.lane_en = st_q.lane_en;
    end
    // Engine-side settings are always writable
    st_d.aux_sel = SW_AUX_SEL;
    st_d.reverse = SW_REVERSE;
    // Readback: all ones while cold
    if (st_d.cold)
    begin
      st_d.mode_rd = '1;
      st_d.ctrl_rd = '1;
      st_d.live_rd = '1;
      st_d.cfg_rd  = '1;
    end
    else
    begin
      st_d.mode_rd = {{(MODE_STAT_W-1){1'b0}}, FW_LANE_DP};
      st_d.ctrl_rd = {{(CTRL_W-1){1'b0}}, st_d.exit_bit};
      st_d.live_rd = FW_LIVE;
      st_d.cfg_rd  = FW_LANE_CFG;
    end
    // Reversal inside engine for legacy use; mux ignores it
    for (int i = 0; i < NUM_LANES; i++)
    begin
      st_d.map_rd[i] = st_d.reverse ? st_d.lane_en[NUM_LANES-1-i]
                                    : st_d.lane_en[i];
    end
  end

  // State register
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // Outputs straight from state or power sequencers
  assign MBOX_BUSY         = st_q.mbox_busy;
  assign COLD_STATE        = st_q.cold;
  assign RD_MODE_STAT      = st_q.mode_rd;
  assign RD_CTRL           = st_q.ctrl_rd;
  assign RD_LIVE           = st_q.live_rd;
  assign RD_LANE_CFG       = st_q.cfg_rd;
  assign RD_AUX_STATE      = pwr;
  assign SAFE_MODE_EXIT    = st_q.exit_bit;
  assign LANE_ENABLE       = st_q.lane_en;
  assign LANE_MAP_REVERSED = st_q.map_rd;
  assign AUX_PATH_SEL      = st_q.aux_sel;
endmodule // tcpo_port_own

// *** dv/tcpo_fw_model.sv ***
// Firmware and lane mux stand-in facing the port ownership block
`timescale 1ns/1ps
module tcpo_fw_model
  import tcpo_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] plug,     // Connection the bench attaches
  input  wire logic [3:0] cfg,      // Pin assignment lanes
  input  wire logic       exit_bit, // Display safe-mode-exit handshake
  output logic            lane_dp,
  output logic [1:0]      live,
  output logic [3:0]      lane_cfg,
  output logic            idle,
  output logic            conn
);
  // Firmware answers one cycle after the plug changes, never sooner
  always_ff @(posedge clk)
  begin
    lane_dp <= !rst && plug != LIVE_TUNNEL; // Alt and static lanes in display mode
    live <= rst ? LIVE_NONE : plug;
    lane_cfg <= rst ? 4'h0 : cfg;
    conn <= !rst && plug != LIVE_NONE;
    idle <= !rst && plug == LIVE_NONE && !exit_bit; // Reclaim after safe state
  end
endmodule // tcpo_fw_model

// *** dv/tcpo_port_own_monitor.sv ***
// Concurrent checks on the port ownership block's top ports
`timescale 1ns/1ps
module tcpo_port_own_monitor
  import tcpo_pkg::*;
#(
  parameter int unsigned MBOX_CYC = 250,
  parameter int unsigned HOLD_CYC = 50
) (
  input wire logic                   CLK,
  input wire logic                   SYS_RST,
  input wire logic                   SW_EXIT_WR,
  input wire logic                   SW_EXIT_VAL,
  input wire logic                   SW_LANE_WR,
  input wire logic [3:0]             SW_LANE_EN,
  input wire logic                   SW_REVERSE,
  input wire tcpo_pkg::tcpo_aux_req_t SW_REQ_BOOT,
  input wire tcpo_pkg::tcpo_aux_req_t SW_REQ_DRV,
  input wire logic                   MBOX_WR,
  input wire logic [7:0]             MBOX_CMD,
  input wire logic                   MBOX_BUSY,
  input wire logic                   COLD_STATE,
  input wire logic [3:0]             RD_CTRL,
  input wire tcpo_pkg::tcpo_aux_state_t RD_AUX_STATE,
  input wire logic                   SAFE_MODE_EXIT,
  input wire logic [3:0]             LANE_ENABLE,
  input wire logic [3:0]             LANE_MAP_REVERSED
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  logic [27:0] bsy_q, hld_q, wt_q; // Busy length, hold window, ack wait
  wire logic leg = SW_REQ_BOOT.legacy_req | SW_REQ_DRV.legacy_req;
  wire logic tun = SW_REQ_BOOT.tunnel_req | SW_REQ_DRV.tunnel_req;
  // Long waits are counted here; repetitions that long would choke tools
  always_ff @(posedge CLK)
  begin
    bsy_q <= (SYS_RST | !MBOX_BUSY) ? 28'h0 : bsy_q + 28'h1;
    wt_q <= (SYS_RST | !leg | COLD_STATE | RD_AUX_STATE.legacy_on) ? 28'h0 : wt_q + 28'h1;
    if (SYS_RST)
      hld_q <= 28'h0;
    else if ($fell(MBOX_BUSY))
      hld_q <= 28'(HOLD_CYC);
    else if (hld_q != 28'h0)
      hld_q <= hld_q - 28'h1;
  end
  sequence s_mbox_go;
    MBOX_WR && MBOX_CMD == MBOX_EXIT_COLD && !MBOX_BUSY;
  endsequence
  sequence s_rev_steady;
    ($stable(SW_REVERSE) && $stable(LANE_ENABLE))[*2];
  endsequence
  a_exit_write: assert property (SW_EXIT_WR && !COLD_STATE
    |=> SAFE_MODE_EXIT == $past(SW_EXIT_VAL))
    else $error("exit bit write lost");
  a_cold_refuse: assert property (COLD_STATE && SW_EXIT_WR
    |=> $stable(SAFE_MODE_EXIT))
    else $error("write taken while cold");
  a_cold_ones: assert property (COLD_STATE |-> RD_CTRL == 4'hF)
    else $error("cold readback not all ones");
  a_lane_write: assert property (SW_LANE_WR && !COLD_STATE
    |=> LANE_ENABLE == $past(SW_LANE_EN))
    else $error("lane enable write lost");
  a_lane_rev: assert property (s_rev_steady |-> LANE_MAP_REVERSED == (SW_REVERSE ?
    {LANE_ENABLE[0], LANE_ENABLE[1], LANE_ENABLE[2], LANE_ENABLE[3]} : LANE_ENABLE))
    else $error("lane map wrong");
  a_mbox_busy: assert property (s_mbox_go |=> MBOX_BUSY[*8])
    else $error("mailbox busy missing");
  a_busy_len: assert property (bsy_q <= 28'(MBOX_CYC + 2))
    else $error("mailbox busy too long");
  a_hold_window: assert property (hld_q > 28'h2 |-> !COLD_STATE)
    else $error("cold entered in hold window");
  a_ack_cold: assert property (COLD_STATE && $past(COLD_STATE)
    |-> RD_AUX_STATE == 2'h0)
    else $error("ack while cold");
  a_ack_hold: assert property (RD_AUX_STATE.legacy_on && leg
    |=> RD_AUX_STATE.legacy_on)
    else $error("ack dropped under request");
  a_ack_drop: assert property (RD_AUX_STATE.legacy_on && !leg
    |=> !RD_AUX_STATE.legacy_on)
    else $error("ack held without request");
  a_ack_wait: assert property (wt_q < 28'd2500)
    else $error("ack later than 10 us");
  a_tun_cause: assert property ($rose(RD_AUX_STATE.tunnel_on) |-> $past(tun))
    else $error("tunnel ack without request");
endmodule // tcpo_port_own_monitor

bind tcpo_port_own tcpo_port_own_monitor #(.MBOX_CYC(MBOX_CYC), .HOLD_CYC(HOLD_CYC)) u_mon (
  .CLK(CLK), .SYS_RST(SYS_RST), .SW_EXIT_WR(SW_EXIT_WR), .SW_EXIT_VAL(SW_EXIT_VAL),
  .SW_LANE_WR(SW_LANE_WR), .SW_LANE_EN(SW_LANE_EN), .SW_REVERSE(SW_REVERSE),
  .SW_REQ_BOOT(SW_REQ_BOOT), .SW_REQ_DRV(SW_REQ_DRV), .MBOX_WR(MBOX_WR),
  .MBOX_CMD(MBOX_CMD), .MBOX_BUSY(MBOX_BUSY), .COLD_STATE(COLD_STATE), .RD_CTRL(RD_CTRL),
  .RD_AUX_STATE(RD_AUX_STATE), .SAFE_MODE_EXIT(SAFE_MODE_EXIT), .LANE_ENABLE(LANE_ENABLE),
  .LANE_MAP_REVERSED(LANE_MAP_REVERSED));

// *** dv/tcpo_port_own_tb.sv ***
// Self-checking bench for the Type-C port ownership block
`timescale 1ns/1ps
module tcpo_port_own_tb;
  import tcpo_pkg::*;
  logic CLK = 1'h0, SYS_RST = 1'h1, ew = 1'h0, ev = 1'h0, lw = 1'h0, mw = 1'h0;
  logic sel = 1'h0, rev = 1'h0, look = 1'h0, ee = 1'h0; // ee: exit bit as software set it
  logic [3:0] len = 4'h0, cfg = 4'h0;
  logic [7:0] cmd = 8'h0;
  logic [1:0] plug = 2'h0;
  tcpo_aux_req_t rb = '0, rd = '0;
  wire logic busy, cold, dp, idle, conn, sme, aps;
  wire logic [1:0] live, rlv;
  wire logic [3:0] fcfg, mst, ctl, rcf, le, lm;
  wire tcpo_aux_state_t ack;
  wire logic [27:0] obs = {sme, aps, cold, busy, ack, rlv, rcf, le, lm, ctl, mst};
  wire logic [3:0] sig = {cold, !busy, ack.tunnel_on, ack.legacy_on};
  logic [27:0] q[$]; // Expected words, oldest first
  int fails = 0, comparisons = 0;
  always #2 CLK = ~CLK;
  tcpo_port_own #(.MBOX_CYC(20), .HOLD_CYC(50)) uut (
    .CLK(CLK), .SYS_RST(SYS_RST), .SW_EXIT_WR(ew), .SW_EXIT_VAL(ev), .SW_LANE_WR(lw),
    .SW_LANE_EN(len), .SW_AUX_SEL(sel), .SW_REVERSE(rev), .SW_REQ_BOOT(rb), .SW_REQ_DRV(rd),
    .MBOX_WR(mw), .MBOX_CMD(cmd), .MBOX_BUSY(busy), .FW_LANE_DP(dp), .FW_LIVE(live),
    .FW_LANE_CFG(fcfg), .FW_PORT_IDLE(idle), .FW_TYPEC_CONN(conn), .COLD_STATE(cold),
    .RD_MODE_STAT(mst), .RD_CTRL(ctl), .RD_LIVE(rlv), .RD_LANE_CFG(rcf),
    .RD_AUX_STATE(ack), .SAFE_MODE_EXIT(sme), .LANE_ENABLE(le), .LANE_MAP_REVERSED(lm),
    .AUX_PATH_SEL(aps));
  tcpo_fw_model fw (.clk(CLK), .rst(SYS_RST), .plug(plug), .cfg(cfg), .exit_bit(sme),
    .lane_dp(dp), .live(live), .lane_cfg(fcfg), .idle(idle), .conn(conn));
  // Whole expected port picture; cold hides the mode, control, live and lane-config readbacks behind all ones
  function automatic logic [27:0] ex(input logic c, input logic b, input logic [1:0] a);
    return {ee, sel, c, b, a, c ? 6'h3F : {plug, cfg}, len,
      rev ? {len[0], len[1], len[2], len[3]} : len,
      c ? 8'hFF : {3'h0, ee, 3'h0, plug != LIVE_TUNNEL}};
  endfunction
  task check(input logic [27:0] s, input logic [27:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task wrap_up();
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Let the ports settle, then leave a note for the watcher
  task note(input logic c, input logic b, input logic [1:0] a);
    repeat (2) @(posedge CLK);
    q.push_back(ex(c, b, a));
    look <= 1'h1;
    @(posedge CLK);
    look <= 1'h0;
  endtask
  // Bounded wait on one status line; running out ends the run
  task waitfor(input int w);
    for (int n = 0; n < 3000; n++)
    begin
      @(posedge CLK);
      if (sig[w] === 1'h1)
        return;
    end
    fails++;
    wrap_up();
  endtask
  task wr_exit(input logic v, input logic tk);
    @(posedge CLK);
    ew <= 1'h1;
    ev <= v;
    if (tk)
      ee <= v;
    @(posedge CLK);
    ew <= 1'h0;
  endtask
  task mbox(input logic [7:0] c);
    @(posedge CLK);
    mw <= 1'h1;
    cmd <= c;
    @(posedge CLK);
    mw <= 1'h0;
  endtask
  // Watcher: oldest note against the ports
  always @(posedge CLK)
    if (look)
      check(obs, q.pop_front());
  initial
  begin
    void'($urandom(50813));
    repeat (10) @(posedge CLK);
    SYS_RST <= 1'h0;
    waitfor(3);
    rd.legacy_req <= 1'h1; // Must neither wake nor ack
    wr_exit(1'h1, 1'h0); // Dropped while cold
    repeat (600) @(posedge CLK); // Past the settle time, still no ack
    note(1'h1, 1'h0, 2'h0);
    rd.legacy_req <= 1'h0;
    mbox(8'h12 ^ 8'(1 + $urandom % 255)); // Other codes refused
    note(1'h1, 1'h0, 2'h0);
    mbox(MBOX_EXIT_COLD);
    note(1'h1, 1'h1, 2'h0);
    waitfor(2);
    wr_exit(1'h1, 1'h1); // Static flow inside the hold window
    rd.legacy_req <= 1'h1;
    waitfor(0);
    @(posedge CLK);
    len <= 4'hF; // Static HDMI keeps all four lanes
    lw <= 1'h1;
    @(posedge CLK);
    lw <= 1'h0;
    note(1'h0, 1'h0, 2'h1);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge CLK);
      plug <= i[0] ? LIVE_TUNNEL : LIVE_ALT;
      sel <= i[0]; // Tunnel path only for tunneled links
      cfg <= 4'($urandom);
      len <= 4'($urandom);
      rev <= i[1];
      lw <= 1'h1;
      @(posedge CLK);
      lw <= 1'h0;
      note(1'h0, 1'h0, 2'h1);
    end
    rb <= '1; // Boot set holds both paths, as self-refresh would
    waitfor(1);
    rd.legacy_req <= 1'h0; // Other holder keeps power
    note(1'h0, 1'h0, 2'h3);
    rb <= '0; // Aux power off before the safe state
    note(1'h0, 1'h0, 2'h0);
    plug <= LIVE_NONE; // Nothing live any more
    wr_exit(1'h0, 1'h1); // Safe state hands the port back
    waitfor(3);
    note(1'h1, 1'h0, 2'h0); // All ones now reads as gone
    plug <= LIVE_ALT; // New connect only after the disconnect
    note(1'h0, 1'h0, 2'h0); // Connect wakes the subsystem
    wrap_up();
  end
endmodule // tcpo_port_own_tb
